// ---- logic/dpc_storage_cell.sv ----
// Dual-port storage cell core with FIFO, error coding and cascade forwarding
`timescale 1ns/1ps
// How it works
// - Split bit selects one 1024-word array or two independent 512-word halves.
// - Width code selects 1, 2, 5, 10, 20, 40 or 80 bit words.
// - Each port write without error coding updates only the data bits whose mask bit is set.
// - Optional per-port output register delays data and flags one port cycle.
// - Hamming (39,32) code with 7 check bits corrects one, detects two errors.
// - Error coding acts only at 40 or 80 bit width.
// - Coded words keep 7 or 14 check bits plus a zero bit per 40-bit word, leaving 32 or 64 payload.
// - Single and double error status leave on dedicated outputs with the data.
// - In FIFO operation internal pointers address storage; address inputs ignored.
// - FIFO pushes on the second port and pops on the first.
// - FIFO runs on one shared clock or separate push and pop clocks.
// - FIFO shows empty, full, almost flags, errors and both pointers.
// - FIFO has its own active-low reset, apart from the port controls.
// - Clock, enable and write enable of each group invert individually.
// - Clock, enable, write enable and address pick one of two inputs.
// - Each group comes from the neighbour cell or from the fabric.
// - Cascade uses address bit 0 to pick upper or lower cell.
// - Whole array merges group pairs into ports A and B (all four groups in simple organisation); split serves halves.
// - Software can preload storage words, so the cell can act as ROM.
// - Mode logic maps four groups onto the storage ports by organisation.
// - Simple organisation: port A only writes, port B only reads on enable.
module dpc_storage_cell (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  input wire dpc_pkg::dpc_grp_in_t [3:0] grp_in,
  input wire dpc_pkg::dpc_grp_in_t [3:0] casc_in,
  input wire logic fifo_rst_n,
  output logic [3:0][19:0] dout_ff,
  output logic [3:0] ecc_sbe_ff,
  output logic [3:0] ecc_dbe_ff,
  output dpc_pkg::dpc_fifo_flags_t fifo_flags_ff,
  output logic [10:0] fifo_rd_ptr_ff,
  output logic [10:0] fifo_wr_ptr_ff,
  output dpc_pkg::dpc_sel_t [3:0] casc_out_ff
);
  localparam int GB = $bits(dpc_pkg::dpc_grp_in_t) * 4;
  localparam int SW = 2 * GB + 1;
  localparam logic [39:0] ONES = 40'hFF_FFFF_FFFF;

  function automatic logic [6:0] wbits(input logic [2:0] c);
    case (c)
      dpc_pkg::W1: wbits = 7'h01;
      dpc_pkg::W2: wbits = 7'h02;
      dpc_pkg::W5: wbits = 7'h05;
      dpc_pkg::W10: wbits = 7'h0A;
      dpc_pkg::W20: wbits = 7'h14;
      dpc_pkg::W40: wbits = 7'h28;
      default: wbits = 7'h50;
    endcase
  endfunction

  // Bit offset of a narrow word inside a stored 40-bit word
  function automatic logic [5:0] offs(input logic [2:0] c, input logic [4:0] a);
    case (c)
      dpc_pkg::W1: offs = {1'b0, a};
      dpc_pkg::W2: offs = {1'b0, a[4:1], 1'b0};
      dpc_pkg::W5: offs = 6'({3'h0, a[4:2]} * 6'h05);
      dpc_pkg::W10: offs = 6'({4'h0, a[4:3]} * 6'h0A);
      dpc_pkg::W20: offs = a[4] ? 6'h14 : 6'h00;
      default: offs = 6'h00;
    endcase
  endfunction

  function automatic logic [39:0] wmask(input logic [2:0] c);
    logic [40:0] m;
    m = 41'((41'h1 << wbits(c)) - 41'h1);
    wmask = (c >= dpc_pkg::W40) ? ONES : m[39:0];
  endfunction

  function automatic logic [38:0] ecc_enc(input logic [31:0] d);
    logic [38:0] c;
    int j;
    c = 39'h0;
    j = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 6; k++) begin
      for (int p = 1; p < 39; p++) begin
        if (p[k] && ((p & (p - 1)) != 0)) begin
          c[1 << k] = c[1 << k] ^ c[p];
        end
      end
    end
    c[0] = ^c[38:1];
    ecc_enc = c;
  endfunction

  // Returns double flag, single flag and corrected payload
  function automatic logic [33:0] ecc_dec(input logic [38:0] r);
    logic [38:0] c;
    logic [5:0] syn;
    logic par;
    logic [31:0] d;
    int j;
    c = r;
    syn = 6'h00;
    d = 32'h0;
    j = 0;
    for (int p = 1; p < 39; p++) begin
      if (c[p]) begin
        syn = syn ^ 6'(p);
      end
    end
    par = ^c;
    if (par && syn < 6'h27) begin
      c[syn] = ~c[syn];
    end
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[j] = c[p];
        j++;
      end
    end
    ecc_dec = {~par & (syn != 6'h00), par, d};
  endfunction

  // Gathers a port's write data or mask from the four groups
  function automatic logic [79:0] pick80(input logic s, input logic h, input int p,
      input logic [79:0] v);
    logic [19:0] g0;
    logic [19:0] g1;
    logic [19:0] g2;
    g0 = v[p * 20 +: 20];
    g1 = v[((p + 1) % 4) * 20 +: 20];
    g2 = v[((p + 2) % 4) * 20 +: 20];
    if (s) begin
      pick80 = h ? {40'h0, g2, g0} : v;
    end else begin
      pick80 = h ? {60'h0, g0} : {40'h0, g1, g0};
    end
  endfunction

  logic [31:0] cfg0_ff;
  logic [31:0] cfg1_ff;
  logic [31:0] fth_ff;
  logic [9:0] iaddr_ff;
  logic [31:0] ilo_ff;
  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  logic [3:0] clk_prev_ff;
  logic [3:0] pv_ff;
  logic [3:0][81:0] pipe_ff;
  logic rerr_ff;
  logic werr_ff;
  logic [39:0] mem [0:dpc_pkg::WORDS-1];

  wire dpc_pkg::dpc_grp_in_t [3:0] grp_s = sync2_ff[GB-1:0];
  wire dpc_pkg::dpc_grp_in_t [3:0] casc_s = sync2_ff[2*GB-1:GB];
  wire fifo_rst_s_n = sync2_ff[SW-1];

  wire split = cfg0_ff[dpc_pkg::CFG0_SPLIT];
  wire fifo = cfg0_ff[dpc_pkg::CFG0_FIFO] & ~split;
  wire simple_dual_port_org = cfg0_ff[dpc_pkg::CFG0_SDP] & ~fifo;
  wire ecc_en = cfg0_ff[dpc_pkg::CFG0_ECC];
  wire ora = cfg0_ff[dpc_pkg::CFG0_ORA];
  wire orb = cfg0_ff[dpc_pkg::CFG0_ORB];
  wire casc = cfg0_ff[dpc_pkg::CFG0_CASC];
  wire cpos = cfg0_ff[dpc_pkg::CFG0_CPOS];
  wire [2:0] wa = cfg0_ff[dpc_pkg::CFG0_WA +: 3];
  wire [2:0] wb = cfg0_ff[dpc_pkg::CFG0_WB +: 3];

  wire dpc_pkg::dpc_sel_t [3:0] sel;
  wire [3:0] edg;
  wire [3:0] wr_go;
  wire [3:0] rd_go;
  wire [3:0] wide_w;
  wire [3:0] orq;
  wire [3:0][9:0] word_w;
  wire [3:0][39:0] w0_w;
  wire [3:0][39:0] m0_w;
  wire [3:0][39:0] w1_w;
  wire [3:0][39:0] m1_w;
  wire [3:0][81:0] rdv_w;

  // Group input selection, alternates and inversion
  for (genvar g = 0; g < 4; g++) begin : gsel
    wire dpc_pkg::dpc_grp_in_t src = cfg1_ff[dpc_pkg::CFG1_FWD + g] ? casc_s[g] : grp_s[g];
    wire alt = cfg1_ff[dpc_pkg::CFG1_ALT + g];
    assign sel[g] = '{
      clk: src.clk[alt] ^ cfg1_ff[dpc_pkg::CFG1_ICLK + g],
      en: src.en[alt] ^ cfg1_ff[dpc_pkg::CFG1_IEN + g],
      we: src.we[alt] ^ cfg1_ff[dpc_pkg::CFG1_IWE + g],
      addr: alt ? src.addr2 : src.addr1,
      di: src.di,
      bm: src.bm};
    assign edg[g] = sel[g].clk & ~clk_prev_ff[g];
  end

  wire [79:0] dis = {sel[3].di, sel[2].di, sel[1].di, sel[0].di};
  wire [79:0] bms = {sel[3].bm, sel[2].bm, sel[1].bm, sel[0].bm};

  wire [10:0] cnt = 11'(fifo_wr_ptr_ff - fifo_rd_ptr_ff);
  wire empty_w = (cnt == 11'h000);
  wire full_w = (cnt == dpc_pkg::FIFO_DEPTH);
  wire push_edge = cfg0_ff[dpc_pkg::CFG0_FASYNC] ? edg[2] : edg[0];
  wire push_try = fifo & push_edge & sel[2].en & sel[2].we;
  wire pop_try = fifo & edg[0] & sel[0].en;
  wire push_ok = push_try & ~full_w;
  wire pop_ok = pop_try & ~empty_w;

  // Per storage port address, data, mask and read path
  for (genvar p = 0; p < 4; p++) begin : gport
    localparam bit IS_A = (p < 2);
    localparam bit HALF = (p % 2 == 1);
    wire [2:0] wcode = IS_A ? wa : wb;
    wire act = split | ~HALF;
    wire ecc_on = ecc_en & (wcode >= dpc_pkg::W40);
    wire wide = (wcode == dpc_pkg::W80) & ~split;
    wire [15:0] ad = sel[p].addr;
    wire cok = ~casc | (ad[0] == cpos);
    wire [5:0] off = (fifo | (wcode >= dpc_pkg::W40)) ? 6'h00 : offs(wcode, ad[5:1]);
    wire [9:0] fptr = IS_A ? fifo_rd_ptr_ff[9:0] : fifo_wr_ptr_ff[9:0];
    wire [9:0] wd = fifo ? fptr :
      split ? {HALF, ad[15:7]} : wide ? {ad[15:7], 1'b0} : ad[15:6];
    wire [79:0] d80 = pick80(simple_dual_port_org, split, p, dis);
    wire [79:0] m80 = pick80(simple_dual_port_org, split, p, bms);
    wire [39:0] wm = wmask(wcode);
    assign w0_w[p] = ecc_on ? {1'b0, ecc_enc(d80[31:0])} : 40'(d80[39:0] << off);
    assign m0_w[p] = ecc_on ? ONES : 40'((m80[39:0] & wm) << off);
    assign w1_w[p] = ecc_on ? {1'b0, ecc_enc(d80[71:40])} : d80[79:40];
    assign m1_w[p] = ecc_on ? ONES : m80[79:40];
    assign word_w[p] = wd;
    assign wide_w[p] = wide;
    wire wr_n = act & edg[p] & sel[p].en & sel[p].we & cok & ~fifo & ~(simple_dual_port_org & ~IS_A);
    assign wr_go[p] = wr_n | ((p == 2) & push_ok);
    wire rd_n = act & edg[p] & sel[p].en & cok & ~fifo & (simple_dual_port_org ? ~IS_A : ~sel[p].we);
    assign rd_go[p] = rd_n | ((p == 0) & pop_ok);
    wire [39:0] r0 = mem[wd];
    wire [39:0] r1 = mem[10'(wd + 10'h001)];
    wire [33:0] e0 = ecc_dec(r0[38:0]);
    wire [33:0] e1 = ecc_dec(r1[38:0]);
    wire [79:0] rn = {wide ? r1 : 40'h0, 40'((r0 >> off) & wm)};
    wire [79:0] re = {8'h00, wide ? e1[31:0] : 32'h0, 8'h00, e0[31:0]};
    wire sb = ecc_on & (e0[32] | (wide & e1[32]));
    wire db = ecc_on & (e0[33] | (wide & e1[33]));
    assign rdv_w[p] = {db, sb, ecc_on ? re : rn};
    assign orq[p] = IS_A ? ora : orb;
  end

  // Which port and which 20-bit piece feed each output group
  wire [3:0] now_w;
  wire [3:0] late_w;
  wire [3:0][1:0] pc_w;
  wire [3:0][81:0] src_w;
  for (genvar g = 0; g < 4; g++) begin : gmap
    wire [1:0] drv = simple_dual_port_org ? (split ? 2'(2 | (g % 2)) : 2'h2) : (split ? 2'(g) : 2'(g & 2));
    assign pc_w[g] = simple_dual_port_org ? (split ? 2'(g / 2) : 2'(g)) : (split ? 2'h0 : 2'(g % 2));
    assign now_w[g] = rd_go[drv] & ~orq[drv];
    assign late_w[g] = edg[drv] & pv_ff[drv] & orq[drv];
    assign src_w[g] = now_w[g] ? rdv_w[drv] : pipe_ff[drv];
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {fifo_rst_n, casc_in, grp_in};
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clk_prev_ff <= 4'h0;
      pv_ff <= 4'h0;
      pipe_ff <= '0;
      casc_out_ff <= '0;
    end else begin
      clk_prev_ff <= {sel[3].clk, sel[2].clk, sel[1].clk, sel[0].clk};
      casc_out_ff <= sel;
      for (int p = 0; p < 4; p++) begin
        if (edg[p]) begin
          pv_ff[p] <= rd_go[p];
        end
        if (rd_go[p]) begin
          pipe_ff[p] <= rdv_w[p];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dout_ff <= '0;
      ecc_sbe_ff <= 4'h0;
      ecc_dbe_ff <= 4'h0;
    end else begin
      for (int g = 0; g < 4; g++) begin
        if (now_w[g] | late_w[g]) begin
          dout_ff[g] <= src_w[g][pc_w[g] * 20 +: 20];
          ecc_sbe_ff[g] <= src_w[g][80];
          ecc_dbe_ff[g] <= src_w[g][81];
        end
      end
    end
  end

  // Storage array; collisions between ports are not arbitrated
  wire init_wr = reg_wr & (reg_addr == dpc_pkg::REG_IHI);
  always_ff @(posedge clk) begin
    if (init_wr) begin
      mem[iaddr_ff] <= {reg_wdata[7:0], ilo_ff};
    end
    for (int p = 0; p < 4; p++) begin
      if (wr_go[p]) begin
        mem[word_w[p]] <= (mem[word_w[p]] & ~m0_w[p]) | (w0_w[p] & m0_w[p]);
      end
      if (wr_go[p] & wide_w[p]) begin
        mem[10'(word_w[p] + 10'h001)] <=
          (mem[10'(word_w[p] + 10'h001)] & ~m1_w[p]) | (w1_w[p] & m1_w[p]);
      end
    end
  end

  // FIFO pointers and sticky error flags
  wire frst = ~reset_n | ~fifo_rst_s_n;
  always_ff @(posedge clk) begin
    if (frst) begin
      fifo_rd_ptr_ff <= 11'h000;
      fifo_wr_ptr_ff <= 11'h000;
      rerr_ff <= 1'b0;
      werr_ff <= 1'b0;
    end else begin
      if (pop_ok) begin
        fifo_rd_ptr_ff <= 11'(fifo_rd_ptr_ff + 11'h001);
      end
      if (push_ok) begin
        fifo_wr_ptr_ff <= 11'(fifo_wr_ptr_ff + 11'h001);
      end
      if (pop_try & empty_w) begin
        rerr_ff <= 1'b1;
      end
      if (push_try & full_w) begin
        werr_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (frst) begin
      fifo_flags_ff <= dpc_pkg::FLAGS_RST;
    end else begin
      fifo_flags_ff <= '{
        empty: empty_w,
        full: full_w,
        aempty: cnt <= fth_ff[dpc_pkg::FTH_AE +: 11],
        afull: cnt >= fth_ff[dpc_pkg::FTH_AF +: 11],
        rerr: rerr_ff,
        werr: werr_ff};
    end
  end

  // Register port
  wire wr_cfg0 = reg_wr & (reg_addr == dpc_pkg::REG_CFG0);
  wire wr_cfg1 = reg_wr & (reg_addr == dpc_pkg::REG_CFG1);
  wire wr_fth = reg_wr & (reg_addr == dpc_pkg::REG_FTH);
  wire wr_iaddr = reg_wr & (reg_addr == dpc_pkg::REG_IADDR);
  wire wr_ilo = reg_wr & (reg_addr == dpc_pkg::REG_ILO);
  wire [31:0] stat_v = {16'h0, ecc_dbe_ff, ecc_sbe_ff, 2'h0, fifo_flags_ff};
  wire [31:0] ptr_v = {5'h00, fifo_wr_ptr_ff, 5'h00, fifo_rd_ptr_ff};
  wire [31:0] rd_mux =
    (reg_addr == dpc_pkg::REG_CFG0) ? cfg0_ff :
    (reg_addr == dpc_pkg::REG_CFG1) ? cfg1_ff :
    (reg_addr == dpc_pkg::REG_FTH) ? fth_ff :
    (reg_addr == dpc_pkg::REG_IADDR) ? {22'h0, iaddr_ff} :
    (reg_addr == dpc_pkg::REG_ILO) ? ilo_ff :
    (reg_addr == dpc_pkg::REG_STAT) ? stat_v :
    (reg_addr == dpc_pkg::REG_PTR) ? ptr_v : 32'h0;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg0_ff <= dpc_pkg::CFG0_RST;
      cfg1_ff <= dpc_pkg::CFG1_RST;
      fth_ff <= dpc_pkg::FTH_RST;
      iaddr_ff <= 10'h000;
      ilo_ff <= 32'h0;
      reg_rdata_ff <= 32'h0;
    end else begin
      if (wr_cfg0) begin
        cfg0_ff <= reg_wdata;
      end
      if (wr_cfg1) begin
        cfg1_ff <= reg_wdata;
      end
      if (wr_fth) begin
        fth_ff <= reg_wdata;
      end
      if (wr_ilo) begin
        ilo_ff <= reg_wdata;
      end
      if (wr_iaddr) begin
        iaddr_ff <= reg_wdata[9:0];
      end else if (init_wr) begin
        iaddr_ff <= 10'(iaddr_ff + 10'h001);
      end
      reg_rdata_ff <= reg_rd ? rd_mux : 32'h0;
    end
  end
endmodule

// ---- logic/dpc_pkg.sv ----
// Shared constants and types for the dual-port storage cell
package dpc_pkg;
  localparam logic [7:0] REG_CFG0 = 8'h00;
  localparam logic [7:0] REG_CFG1 = 8'h04;
  localparam logic [7:0] REG_FTH = 8'h08;
  localparam logic [7:0] REG_IADDR = 8'h0C;
  localparam logic [7:0] REG_ILO = 8'h10;
  localparam logic [7:0] REG_IHI = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;
  localparam logic [7:0] REG_PTR = 8'h1C;

  localparam int CFG0_SPLIT = 0;
  localparam int CFG0_SDP = 1;
  localparam int CFG0_FIFO = 2;
  localparam int CFG0_FASYNC = 3;
  localparam int CFG0_ECC = 4;
  localparam int CFG0_ORA = 5;
  localparam int CFG0_ORB = 6;
  localparam int CFG0_CASC = 7;
  localparam int CFG0_WA = 8;
  localparam int CFG0_WB = 12;
  localparam int CFG0_CPOS = 16;
  localparam int CFG1_ALT = 0;
  localparam int CFG1_FWD = 4;
  localparam int CFG1_ICLK = 8;
  localparam int CFG1_IEN = 12;
  localparam int CFG1_IWE = 16;
  localparam int FTH_AE = 0;
  localparam int FTH_AF = 16;
  localparam int STAT_SBE = 8;
  localparam int STAT_DBE = 12;
  localparam int PTR_WR = 16;

  localparam logic [31:0] CFG0_RST = 32'h0000_0000;
  localparam logic [31:0] CFG1_RST = 32'h0000_0000;
  localparam logic [31:0] FTH_RST = 32'h03FC_0004;

  localparam logic [2:0] W1 = 3'h0;
  localparam logic [2:0] W2 = 3'h1;
  localparam logic [2:0] W5 = 3'h2;
  localparam logic [2:0] W10 = 3'h3;
  localparam int W20_CODE = 4;
  localparam logic [2:0] W20 = 3'h4;
  localparam logic [2:0] W40 = 3'h5;
  localparam logic [2:0] W80 = 3'h6;

  localparam int WORDS = 1024;
  localparam logic [10:0] FIFO_DEPTH = 11'h400;

  typedef struct packed {
    logic [1:0] clk;
    logic [1:0] en;
    logic [1:0] we;
    logic [15:0] addr2;
    logic [15:0] addr1;
    logic [19:0] di;
    logic [19:0] bm;
  } dpc_grp_in_t;

  typedef struct packed {
    logic clk;
    logic en;
    logic we;
    logic [15:0] addr;
    logic [19:0] di;
    logic [19:0] bm;
  } dpc_sel_t;

  typedef struct packed {
    logic empty;
    logic full;
    logic aempty;
    logic afull;
    logic rerr;
    logic werr;
  } dpc_fifo_flags_t;

  localparam dpc_fifo_flags_t FLAGS_RST = 6'h28;
endpackage

// ---- test/dpc_monitor.sv ----
// Port checker for the dual-port storage cell
`timescale 1ns/1ps
module dpc_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata_ff,
  input wire logic fifo_rst_n,
  input wire dpc_pkg::dpc_fifo_flags_t fifo_flags_ff,
  input wire logic [10:0] fifo_rd_ptr_ff,
  input wire logic [10:0] fifo_wr_ptr_ff
);
  logic [3:0] since_ff;
  logic [3:0] nxt_since;
  logic [10:0] fill;
  assign nxt_since = !fifo_rst_n ? 4'h0 : (since_ff == 4'hF ? since_ff : since_ff + 4'h1);
  assign fill = fifo_wr_ptr_ff - fifo_rd_ptr_ff;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      since_ff <= 4'h0;
    end else begin
      since_ff <= nxt_since;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata_ff == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_frst;
    !fifo_rst_n [*5] |=> fifo_flags_ff == dpc_pkg::FLAGS_RST && fifo_rd_ptr_ff == 11'h0;
  endproperty
  a_frst: assert property (p_frst) else $error("fifo reset not applied");
  property p_excl;
    !(fifo_flags_ff.empty && fifo_flags_ff.full);
  endproperty
  a_excl: assert property (p_excl) else $error("empty and full together");
  property p_rptr;
    $changed(fifo_rd_ptr_ff) |-> fifo_rd_ptr_ff == $past(fifo_rd_ptr_ff) + 11'h1
      || fifo_rd_ptr_ff == 11'h0;
  endproperty
  a_rptr: assert property (p_rptr) else $error("read pointer jump");
  property p_wptr;
    $changed(fifo_wr_ptr_ff) |-> fifo_wr_ptr_ff == $past(fifo_wr_ptr_ff) + 11'h1
      || fifo_wr_ptr_ff == 11'h0;
  endproperty
  a_wptr: assert property (p_wptr) else $error("write pointer jump");
  property p_werr;
    $fell(fifo_flags_ff.werr) |-> since_ff < 4'h8;
  endproperty
  a_werr: assert property (p_werr) else $error("write error not sticky");
  property p_full;
    fifo_flags_ff.full |-> $past(fill) == 11'h400;
  endproperty
  a_full: assert property (p_full) else $error("full flag wrong");
  property p_empty;
    fifo_flags_ff.empty && since_ff > 4'h6 |-> $past(fill) == 11'h0;
  endproperty
  a_empty: assert property (p_empty) else $error("empty flag wrong");
endmodule

// ---- test/dpc_fabric_model.sv ----
// Fabric-side driver model for the four port signal groups
`timescale 1ns/1ps
module dpc_fabric_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] go,
  input wire dpc_pkg::dpc_grp_in_t [3:0] req,
  output dpc_pkg::dpc_grp_in_t [3:0] grp_in,
  output logic busy
);
  logic [2:0] phase_ff;
  logic [3:0] act_ff;
  assign busy = phase_ff != 3'h0;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_ff <= 3'h0;
      act_ff <= 4'h0;
      grp_in <= '0;
    end else if (go != 4'h0) begin
      phase_ff <= 3'h1;
      act_ff <= go;
      for (int g = 0; g < 4; g++) begin
        if (go[g]) begin
          grp_in[g] <= req[g];
        end
      end
    end else if (busy) begin
      phase_ff <= phase_ff + 3'h1;
      for (int g = 0; g < 4; g++) begin
        if (act_ff[g] && phase_ff == 3'h1) begin
          grp_in[g].clk[0] <= 1'b1;
        end else if (act_ff[g] && phase_ff == 3'h4) begin
          grp_in[g].clk[0] <= 1'b0;
        end else if (act_ff[g] && phase_ff == 3'h7) begin
          grp_in[g].en <= 2'b00;
          grp_in[g].we <= 2'b00;
          grp_in[g].di <= ~grp_in[g].di;
        end
      end
    end
  end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the dual-port storage cell
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fifo_rst_n = 1'b1;
  logic [3:0] go = 4'h0;
  logic busy;
  dpc_pkg::dpc_grp_in_t [3:0] req = '0;
  dpc_pkg::dpc_grp_in_t [3:0] grp_in;
  logic [31:0] reg_rdata_ff;
  logic [3:0][19:0] dout_ff;
  logic [3:0] ecc_sbe_ff;
  logic [3:0] ecc_dbe_ff;
  dpc_pkg::dpc_fifo_flags_t fifo_flags_ff;
  dpc_pkg::dpc_sel_t [3:0] casc_out_ff;
  logic [10:0] fifo_rd_ptr_ff;
  logic [10:0] fifo_wr_ptr_ff;
  int n_fail = 0;
  int samples_checked = 0;
  always #2.5 clk = ~clk;
  dpc_fabric_model u_fab (.clk(clk), .reset_n(reset_n), .go(go), .req(req),
    .grp_in(grp_in), .busy(busy));
  dpc_storage_cell u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .grp_in(grp_in), .casc_in('0), .fifo_rst_n(fifo_rst_n), .dout_ff(dout_ff),
    .ecc_sbe_ff(ecc_sbe_ff), .ecc_dbe_ff(ecc_dbe_ff), .fifo_flags_ff(fifo_flags_ff),
    .fifo_rd_ptr_ff(fifo_rd_ptr_ff), .fifo_wr_ptr_ff(fifo_wr_ptr_ff),
    .casc_out_ff(casc_out_ff));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("register", exp, reg_rdata_ff);
  endtask
  function automatic dpc_pkg::dpc_grp_in_t mk(input logic w, input logic [15:0] a,
      input logic [19:0] d, input logic [19:0] m);
    mk = '0;
    mk.en = 2'b01;
    mk.we = {1'b0, w};
    mk.addr1 = a;
    mk.addr2 = a;
    mk.di = d;
    mk.bm = m;
  endfunction
  task automatic fire(input logic [3:0] m);
    @(posedge clk);
    go <= m;
    @(posedge clk);
    go <= 4'h0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic summarize;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd(dpc_pkg::REG_CFG0, dpc_pkg::CFG0_RST);
    rd(dpc_pkg::REG_FTH, dpc_pkg::FTH_RST);
    rd(dpc_pkg::REG_STAT, 32'h0000_0028);
    rd(8'hF0, 32'h0);
    wr(dpc_pkg::REG_CFG0, 32'h0000_5500);
    wr(dpc_pkg::REG_IADDR, 32'h0000_0003);
    wr(dpc_pkg::REG_ILO, 32'h1234_5678);
    wr(dpc_pkg::REG_IHI, 32'h0000_00A5);
    rd(dpc_pkg::REG_IADDR, 32'h0000_0004);
    req[0] = mk(1'b0, 16'h00C0, 20'h0, 20'h0);
    req[1] = req[0];
    fire(4'b0011);
    chk("dout0", 32'h0004_5678, {12'h0, dout_ff[0]});
    chk("dout1", 32'h000A_5123, {12'h0, dout_ff[1]});
    req[2] = mk(1'b1, 16'h00C0, 20'hFFFFF, 20'h000F0);
    req[3] = mk(1'b1, 16'h00C0, 20'h0, 20'hFFFFF);
    fire(4'b1100);
    fire(4'b0011);
    chk("dout0", 32'h0004_56F8, {12'h0, dout_ff[0]});
    chk("dout1", 32'h0, {12'h0, dout_ff[1]});
    wr(dpc_pkg::REG_CFG0, 32'h0000_5540);
    req[2] = mk(1'b0, 16'h00C0, 20'h0, 20'h0);
    fire(4'b0100);
    chk("dout2", 32'h0, {12'h0, dout_ff[2]});
    fire(4'b0100);
    chk("dout2", 32'h0004_56F8, {12'h0, dout_ff[2]});
    wr(dpc_pkg::REG_CFG0, 32'h0000_5510);
    req[0] = mk(1'b1, 16'h01C0, 20'h9ABCD, 20'hFFFFF);
    req[1] = mk(1'b1, 16'h01C0, 20'h01234, 20'hFFFFF);
    fire(4'b0011);
    req[2] = mk(1'b0, 16'h01C0, 20'h0, 20'h0);
    fire(4'b0100);
    chk("dout2", 32'h0009_ABCD, {12'h0, dout_ff[2]});
    chk("dout3", 32'h0000_0234, {20'h0, dout_ff[3][11:0]});
    chk("ecc", 32'h0, {24'h0, ecc_sbe_ff, ecc_dbe_ff});
    wr(dpc_pkg::REG_CFG0, 32'h0000_550C);
    for (int i = 0; i < 1025; i++) begin
      req[2] = mk(1'b1, 16'h0, i[19:0], 20'hFFFFF);
      req[3] = mk(1'b1, 16'h0, 20'h0, 20'hFFFFF);
      fire(4'b1100);
    end
    chk("wr_ptr", 32'h0000_0400, {21'h0, fifo_wr_ptr_ff});
    chk("flags", 32'h0000_0015, {26'h0, fifo_flags_ff});
    req[0] = mk(1'b0, 16'hFFFF, 20'h0, 20'h0);
    req[1] = req[0];
    fire(4'b0011);
    chk("dout0", 32'h0, {12'h0, dout_ff[0]});
    fire(4'b0011);
    chk("dout0", 32'h0000_0001, {12'h0, dout_ff[0]});
    chk("flags", 32'h0000_0005, {26'h0, fifo_flags_ff});
    rd(dpc_pkg::REG_PTR, 32'h0400_0002);
    chk("rd_ptr", 32'h0000_0002, {21'h0, fifo_rd_ptr_ff});
    @(posedge clk);
    fifo_rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    fifo_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("flags", 32'h0000_0028, {26'h0, fifo_flags_ff});
    fire(4'b0011);
    chk("flags", 32'h0000_002A, {26'h0, fifo_flags_ff});
    wr(dpc_pkg::REG_CFG0, 32'h0000_5504);
    req[2] = mk(1'b1, 16'h0, 20'h00007, 20'hFFFFF);
    fire(4'b0100);
    chk("wr_ptr", 32'h0, {21'h0, fifo_wr_ptr_ff});
    fire(4'b0101);
    chk("wr_ptr", 32'h0000_0001, {21'h0, fifo_wr_ptr_ff});
    wr(dpc_pkg::REG_CFG0, 32'h0000_4401);
    req[1] = mk(1'b1, 16'h0, 20'h12345, 20'hFFFFF);
    fire(4'b0010);
    req[2] = mk(1'b0, 16'h0, 20'h0, 20'h0);
    req[3] = req[2];
    fire(4'b1100);
    chk("dout3", 32'h0001_2345, {12'h0, dout_ff[3]});
    chk("dout2", 32'h0000_0007, {12'h0, dout_ff[2]});
    wr(dpc_pkg::REG_CFG1, 32'h0000_1000);
    repeat (2) @(posedge clk);
    #1;
    chk("casc_en", 32'h0000_0001, {31'h0, casc_out_ff[0].en});
    chk("casc_addr", 32'h0000_FFFF, {16'h0, casc_out_ff[0].addr});
    summarize();
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule
bind dpc_storage_cell dpc_monitor u_mon (.clk(clk), .reset_n(reset_n), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .fifo_rst_n(fifo_rst_n), .fifo_flags_ff(fifo_flags_ff),
  .fifo_rd_ptr_ff(fifo_rd_ptr_ff), .fifo_wr_ptr_ff(fifo_wr_ptr_ff));
